// *** acx_phase_gen.sv ***
`timescale 1ns/1ps
module excite_phase_gen
   import excite_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Control from the conversion logic (pins, other timing)
   input wire logic ac_excitation_enable,
   input wire logic toggle_req,
   // Bridge switch drives
   output logic excitation_phase_a,
   output logic excitation_phase_a_n,
   output logic excitation_phase_b,
   output logic excitation_phase_b_n
);
   // One request: normal, then dead, then reversed; the next one walks back.
   // Dead opens both switches for DEAD_CYCLES clocks, so the bridge supply
   // never sees a and b closed together.
   // The toggle input is a level: each change, either way, asks for one flip.
   // Requests that land while dead runs are dropped, so space them two
   // clocks apart or more.
   // Disabling from reversed takes the dead path as well, so b is low before
   // a returns high; disabling from normal moves no pin.
   // Both controls are synchronised, so pins follow an input three clocks late.

   // One-hot states; any other code is treated as illegal
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_NORMAL = 4'h2,
      ST_DEAD = 4'h4,
      ST_REVERSED = 4'h8
   } state_t;

   state_t state_q, state_d;
   state_t target_q, target_d;
   logic enable_s;
   logic toggle_s;
   logic toggle_prev_q;
   logic toggle_edge;
   logic [7:0] dead_cnt_q;
   logic dead_done;
   // Next drive levels and the four pin flops
   logic phase_a_d, phase_b_d;
   logic phase_a_q, phase_b_q;
   logic phase_a_n_q, phase_b_n_q;

   // Both controls may come from outside this clock
   excite_sync u_sync_en (
      .core_clk(core_clk),
      .rstn(rstn),
      .async_in(ac_excitation_enable),
      .sync_out(enable_s)
   );

   // Toggle level; every change, either way, is one request
   excite_sync u_sync_tg (
      .core_clk(core_clk),
      .rstn(rstn),
      .async_in(toggle_req),
      .sync_out(toggle_s)
   );

   // Each request edge seen in normal or reversed flips the polarity once; edges in idle or dead are lost
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         toggle_prev_q <= 1'h0;
      else
         toggle_prev_q <= toggle_s;
   end

   assign toggle_edge = toggle_s ^ toggle_prev_q;

   // Polarity sequencer: every change passes through the dead state
   always_comb
   begin
      state_d = state_q;
      target_d = target_q;
      unique case (state_q)
         ST_IDLE:
         begin
            // Idle and normal share levels, so enabling moves no pin
            if (enable_s)
               state_d = ST_NORMAL;
         end
         ST_NORMAL:
         begin
            // Disable from normal needs no dead cycle; a is already high
            if (!enable_s)
               state_d = ST_IDLE;
            else if (toggle_edge)
            begin
               state_d = ST_DEAD;
               target_d = ST_REVERSED;
            end
         end
         ST_REVERSED:
         begin
            // Disable also goes through dead so b falls before a rises
            if (!enable_s || toggle_edge)
            begin
               state_d = ST_DEAD;
               target_d = enable_s ? ST_NORMAL : ST_IDLE;
            end
         end
         ST_DEAD:
         begin
            // Requests seen here are dropped; the caller must space them
            if (dead_done)
               state_d = enable_s ? target_q : ST_IDLE;
         end
         default:
            // Illegal code: recover to the idle levels
            state_d = ST_IDLE;
      endcase
   end

   // State and the pending target move together
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= ST_IDLE;
         target_q <= ST_NORMAL;
      end
      else
      begin
         state_q <= state_d;
         target_q <= target_d;
      end
   end

   // Dead interval length in master clocks
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         dead_cnt_q <= 8'h00;
      else if (state_q == ST_DEAD)
         dead_cnt_q <= dead_cnt_q + 8'h01;
      else
         dead_cnt_q <= 8'h00;
   end

   // Last dead cycle; an equality test never degenerates into a constant
   assign dead_done = (dead_cnt_q == 8'(DEAD_CYCLES - 1));

   // Drive levels for the coming cycle, decoded from the next state
   always_comb
   begin
      phase_a_d = PHASE_A_IDLE;
      phase_b_d = PHASE_B_IDLE;
      unique case (state_d)
         ST_IDLE:
         begin
            phase_a_d = PHASE_A_IDLE;
            phase_b_d = PHASE_B_IDLE;
         end
         ST_NORMAL:
         begin
            phase_a_d = 1'h1;
            phase_b_d = 1'h0;
         end
         ST_REVERSED:
         begin
            phase_a_d = 1'h0;
            phase_b_d = 1'h1;
         end
         ST_DEAD:
         begin
            // Both switches open: break before make
            phase_a_d = 1'h0;
            phase_b_d = 1'h0;
         end
         default:
         begin
            // Corrupt code opens both switches rather than risk a short
            phase_a_d = 1'h0;
            phase_b_d = 1'h0;
         end
      endcase
   end

   // Phase a and its complement load together, so they never disagree
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         phase_a_q <= PHASE_A_IDLE;
         phase_a_n_q <= ~PHASE_A_IDLE;
      end
      else
      begin
         phase_a_q <= phase_a_d;
         phase_a_n_q <= ~phase_a_d;
      end
   end

   // Phase b pair, same scheme
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         phase_b_q <= PHASE_B_IDLE;
         phase_b_n_q <= ~PHASE_B_IDLE;
      end
      else
      begin
         phase_b_q <= phase_b_d;
         phase_b_n_q <= ~phase_b_d;
      end
   end

   // Pins come straight from flops; a decode glitch never reaches a switch
   // and each complement is an exact inverse at every edge
   assign excitation_phase_a = phase_a_q;
   assign excitation_phase_a_n = phase_a_n_q;
   assign excitation_phase_b = phase_b_q;
   assign excitation_phase_b_n = phase_b_n_q;
endmodule

// *** acx_pkg.sv ***
package excite_pkg;
   // Idle levels while excitation is off
   localparam logic PHASE_A_IDLE = 1'h1;
   localparam logic PHASE_B_IDLE = 1'h0;
   // Width of the enable and toggle-request synchronisers
   localparam int SYNC_STAGES = 2;
   // Master clock period in ns; dead interval is one period
   localparam int CLK_PERIOD_NS = 40;
   localparam int DEAD_TIME_NS = 40;
   localparam int DEAD_CYCLES = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// *** acx_sync.sv ***
`timescale 1ns/1ps
module excite_sync
   import excite_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Asynchronous level in, synchronised level out
   input wire logic async_in,
   output logic sync_out
);
   logic [SYNC_STAGES-1:0] stage_q;

   // Two-flop chain; only the last stage is read
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         stage_q <= '0;
      else
         stage_q <= {stage_q[SYNC_STAGES-2:0], async_in};
   end

   assign sync_out = stage_q[SYNC_STAGES-1];
endmodule

// *** acx_props.sv ***
`timescale 1ns/1ps
module excite_props(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Control and drives
   input wire logic ac_excitation_enable,
   input wire logic toggle_req,
   input wire logic excitation_phase_a,
   input wire logic excitation_phase_a_n,
   input wire logic excitation_phase_b,
   input wire logic excitation_phase_b_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Short aliases; idle checks wait out the synchroniser
   wire en = ac_excitation_enable;
   wire pa = excitation_phase_a;
   wire pb = excitation_phase_b;
   wire tg = toggle_req;
   a_no_overlap: assert property (!(pa && pb)) else $error("phases overlap");
   a_b_gap: assert property ($rose(pb) |-> !$past(pa)) else $error("no gap before b");
   a_a_gap: assert property ($rose(pa) |-> !$past(pb)) else $error("no gap before a");
   a_b_idle: assert property (!en [*6] |-> !pb) else $error("b not idle");
   a_a_idle: assert property (!en [*6] |-> pa) else $error("a not idle");
   a_b_inverse: assert property (excitation_phase_b_n == !pb) else $error("b_n bad");
   a_a_inverse: assert property (excitation_phase_a_n == !pa) else $error("a_n bad");
   a_toggle_flip: assert property (en [*4] ##0 $changed(tg) && pa |-> ##[1:4] !pa)
      else $error("no flip");
   a_toggle_back: assert property (en [*4] ##0 $changed(tg) && pb |-> ##[1:4] !pb)
      else $error("no flip back");
   c_rev: cover property ($fell(pa));
   c_back: cover property ($rose(pa) && en);
   c_off: cover property (!en ##1 pa);
endmodule
bind excite_phase_gen excite_props chk(.core_clk, .rstn, .ac_excitation_enable, .toggle_req,
   .excitation_phase_a, .excitation_phase_a_n, .excitation_phase_b, .excitation_phase_b_n);

// *** bridge_switches.sv ***
`timescale 1ns/1ps
module bridge_switches(
   // Switch gate drives
   input wire logic drive_a,
   input wire logic drive_b,
   // Bridge state
   output logic reversed
);
   // Only b closed swaps the bridge; a low alone is the dead gap
   assign reversed = drive_b && !drive_a;
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
   logic core_clk = 0, rstn = 0, en = 0, tog = 0;
   logic pa, pa_n, pb, pb_n, rev;
   int errors = 0, samples_checked = 0, cyc = 0;
   // 25 MHz master clock
   initial forever #20 core_clk = ~core_clk;
   excite_phase_gen DUT(.core_clk, .rstn, .ac_excitation_enable(en), .toggle_req(tog),
      .excitation_phase_a(pa), .excitation_phase_a_n(pa_n), .excitation_phase_b(pb),
      .excitation_phase_b_n(pb_n));
   bridge_switches sw(.drive_a(pa), .drive_b(pb), .reversed(rev));
   task automatic chk(string nm, logic [3:0] exp, logic [3:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask
   // Bridge polarity as the switch model sees it
   task automatic chk_rev(logic exp);
      samples_checked++;
      if (rev !== exp)
      begin
         errors++;
         $display("wrong value reversed exp %b got %b", exp, rev);
      end
   endtask
   task tally_and_finish;
      $display("errors %0d checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Sample 1 ns after the edge so its updates have landed
   task wt(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Drive at an edge; outputs move 3 edges on, gap then final
   task automatic step(logic e, logic t, logic [3:0] d, logic [3:0] f);
      @(posedge core_clk);
      en <= e;
      tog <= tog ^ t;
      wt(3);
      chk("gap", d, {pa, pa_n, pb, pb_n});
      wt(1);
      chk("final", f, {pa, pa_n, pb, pb_n});
   endtask
   task s_idle;
      wt(2);
      chk("idle", 4'h9, {pa, pa_n, pb, pb_n});
      chk_rev(1'h0);
      step(1'h1, 1'h0, 4'h9, 4'h9);
   endtask
   task s_toggle;
      step(1'h1, 1'h1, 4'h5, 4'h6);
      chk_rev(1'h1);
      step(1'h1, 1'h1, 4'h5, 4'h9);
   endtask
   // A second request inside the dead cycle is dropped
   task s_refuse;
      @(posedge core_clk);
      tog <= ~tog;
      @(posedge core_clk);
      tog <= ~tog;
      wt(2);
      chk("refuse gap", 4'h5, {pa, pa_n, pb, pb_n});
      wt(2);
      chk("refuse hold", 4'h6, {pa, pa_n, pb, pb_n});
      chk_rev(1'h1);
      step(1'h1, 1'h1, 4'h5, 4'h9);
   endtask
   task s_disable;
      step(1'h1, 1'h1, 4'h5, 4'h6);
      step(1'h0, 1'h0, 4'h5, 4'h9);
      step(1'h0, 1'h1, 4'h9, 4'h9);
      step(1'h1, 1'h0, 4'h9, 4'h9);
      step(1'h1, 1'h1, 4'h5, 4'h6);
      chk_rev(1'h1);
   endtask
   // Hang guard
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 500)
      begin
         errors++;
         tally_and_finish;
      end
   end
   initial
   begin
      repeat (5) @(posedge core_clk);
      rstn <= 1'h1;
      s_idle;
      s_toggle;
      s_refuse;
      s_disable;
      tally_and_finish;
   end
endmodule
